// [hdl/switch_cfg_pkg.sv]
// Contract
// - conformance drop mode drops type 0x8808 frames and DA 01-80-C2-00-00-01 frames.
// - conformance drop mode clear drops only frames classified as flow-control pause.
// - link loss with link-change aging runs one fast cycle under 800 us.
// - normal aging removes learned entries after 300 s, tolerance 75 s.
// - while aging is enabled, any port losing link ages out all learned addresses.
// - pass-all bit forwards every frame, errored ones included, for sniffer debug.
// - long-frame bit accepts frames up to 2K bytes; clearing withdraws that.
// - bit 5 clear follows autonegotiation for transmit pause; set forces it off.
// - bit 4 clear follows autonegotiation for receive pause; set forces it off.
// - both pause-disable bits load from one strap; afterwards written independently.
// - length check drops frames with length below 1500 and mismatched payload.
// - aging enable resets to one; when zero nothing ages.
// - fast-age bit selects an aging period one cycle under 800 us while set.
package switch_cfg_pkg;
  // register offsets on the management register port
  localparam logic [7:0] ADDR_DROP_LINKAGE = 8'h02;
  localparam logic [7:0] ADDR_FILTER_AGING = 8'h03;
  // bit positions, drop/linkage register
  localparam int BIT_CONF_DROP = 1;
  localparam int BIT_LINK_AGE = 0;
  // bit positions, filter/aging register
  localparam int BIT_PASS_ALL = 7;
  localparam int BIT_LONG_FRAME = 6;
  localparam int BIT_TX_PAUSE_DIS = 5;
  localparam int BIT_RX_PAUSE_DIS = 4;
  localparam int BIT_LEN_CHECK = 3;
  localparam int BIT_AGE_EN = 2;
  localparam int BIT_FAST_AGE = 1;
  localparam int BIT_AGGR_BACKOFF = 0;
  // reset values and implemented-bit masks
  localparam logic [7:0] RST_DROP_LINKAGE = 8'h00;
  localparam logic [7:0] RST_FILTER_AGING = 8'h04;
  localparam logic [7:0] MASK_DROP_LINKAGE = 8'h03;
  // frame classification constants
  localparam logic [15:0] PAUSE_ETHERTYPE = 16'h8808;
  localparam logic [47:0] RESERVED_MC_DA = 48'h0180C2000001;
  localparam logic [15:0] LEN_CHECK_LIMIT = 16'h05DC;
  localparam logic [11:0] LONG_FRAME_BYTES = 12'h800;
  localparam logic [11:0] STD_FRAME_BYTES = 12'h5EE;
  // verdict reason codes
  localparam logic [3:0] REASON_NONE = 4'h0;
  localparam logic [3:0] REASON_PAUSE = 4'h1;
  localparam logic [3:0] REASON_ERRORED = 4'h2;
  localparam logic [3:0] REASON_OVERSIZE = 4'h3;
  localparam logic [3:0] REASON_LENGTH = 4'h4;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NORMAL_AGE_S = 300;
  localparam int unsigned AGE_TOLERANCE_S = 75;
  localparam int unsigned FAST_AGE_US = 800;
  localparam logic [31:0] NORMAL_AGE_CYCLES = 32'((64'(NORMAL_AGE_S) * 64'd1000000000) / 64'(CLK_PERIOD_NS));
  // one cycle short so the fast period is strictly under the limit
  localparam logic [31:0] FAST_AGE_CYCLES = 32'((FAST_AGE_US * 1000) / CLK_PERIOD_NS - 1);
endpackage : switch_cfg_pkg

// [hdl/switch_cfg_if.sv]
`timescale 1ns/1ps
interface switch_cfg_if;
  logic ageEnable;
  logic fastAge;
  logic linkChangeAge;
  logic linkLoss;
  logic ageAllFlush;
  logic ageTick;
  logic fastActive;
  modport bank (output ageEnable, output fastAge, output linkChangeAge,
    input linkLoss, input ageAllFlush, input ageTick, input fastActive);
  modport timer (input ageEnable, input fastAge, input linkChangeAge, input linkLoss,
    output ageTick, output fastActive);
  modport monitor (input ageEnable, output linkLoss, output ageAllFlush);
endinterface : switch_cfg_if

// [hdl/link_loss_monitor.sv]
`timescale 1ns/1ps
module link_loss_monitor #(
  parameter int N_PORTS = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [N_PORTS-1:0] linkUp,
  switch_cfg_if.monitor cfg
);
  typedef struct packed {
    logic [N_PORTS-1:0] linkPrev;
    logic linkLoss;
    logic ageAllFlush;
  } monitor_state_t;

  monitor_state_t s;
  monitor_state_t next_s;

  // link up to link down on any port, one pulse per event cycle
  always_comb
  begin
    next_s = s;
    next_s.linkPrev = linkUp;
    next_s.linkLoss = |(s.linkPrev & ~linkUp);
    // flush is held back while aging is off, nothing may age then
    next_s.ageAllFlush = cfg.ageEnable && (|(s.linkPrev & ~linkUp));
  end

  // all ports assumed down at reset so no spurious loss edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  assign cfg.linkLoss = s.linkLoss;
  assign cfg.ageAllFlush = s.ageAllFlush;
endmodule : link_loss_monitor

// [hdl/age_timer.sv]
`timescale 1ns/1ps
module age_timer #(
  parameter logic [31:0] NORMAL_AGE_CYCLES = switch_cfg_pkg::NORMAL_AGE_CYCLES,
  parameter logic [31:0] FAST_AGE_CYCLES = switch_cfg_pkg::FAST_AGE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  switch_cfg_if.timer cfg
);
  typedef enum logic [1:0] {AGE_OFF, AGE_NORMAL, AGE_LINK_FAST} age_mode_t;
  typedef struct packed {
    age_mode_t mode;
    logic [31:0] count;
    logic tick;
    logic fastActive;
  } age_state_t;

  age_state_t s;
  age_state_t next_s;
  logic useFast;

  // fast period while the bit is set or a link-loss cycle runs
  assign useFast = cfg.fastAge || (s.mode == AGE_LINK_FAST);

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    unique case (s.mode)
      AGE_OFF:
      begin
        next_s.count = '0;
        if (cfg.ageEnable)
          next_s.mode = AGE_NORMAL;
      end
      AGE_NORMAL, AGE_LINK_FAST:
      begin
        if (!cfg.ageEnable)
        begin
          next_s.mode = AGE_OFF;
          next_s.count = '0;
        end
        else if (cfg.linkLoss && cfg.linkChangeAge)
        begin
          // a new loss restarts the single fast cycle
          next_s.mode = AGE_LINK_FAST;
          next_s.count = '0;
        end
        else if (s.count >= (useFast ? FAST_AGE_CYCLES : NORMAL_AGE_CYCLES) - 32'h1)
        begin
          next_s.tick = 1'b1;
          next_s.count = '0;
          next_s.mode = AGE_NORMAL;
        end
        else
          next_s.count = s.count + 32'h1;
      end
      // unused code: fall back to the idle state
      default:
      begin
        next_s.mode = AGE_OFF;
        next_s.count = '0;
      end
    endcase
    next_s.fastActive = cfg.ageEnable && (cfg.fastAge || next_s.mode == AGE_LINK_FAST);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s <= '{mode: AGE_OFF, count: '0, tick: 1'b0, fastActive: 1'b0};
    else
      s <= next_s;
  end

  assign cfg.ageTick = s.tick;
  assign cfg.fastActive = s.fastActive;
endmodule : age_timer

// [hdl/switch_global_frame_aging_control.sv]
`timescale 1ns/1ps
module switch_global_frame_aging_control #(
  parameter int N_PORTS = 4,
  parameter logic [31:0] NORMAL_AGE_CYCLES = switch_cfg_pkg::NORMAL_AGE_CYCLES,
  parameter logic [31:0] FAST_AGE_CYCLES = switch_cfg_pkg::FAST_AGE_CYCLES,
  parameter logic [11:0] STD_FRAME_BYTES = switch_cfg_pkg::STD_FRAME_BYTES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pauseDisableStrapPin,
  // management register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // frame descriptor from the receive side
  input wire logic frameValid,
  input wire logic [15:0] frameTypeLen,
  input wire logic [47:0] frameDestAddr,
  input wire logic frameIsPause,
  input wire logic frameErrored,
  input wire logic [11:0] frameBytes,
  input wire logic [11:0] framePayloadBytes,
  output logic verdictValid,
  output logic verdictDrop,
  output logic [3:0] verdictReason,
  // pause flow control
  input wire logic autonegotiationTxPause,
  input wire logic autonegotiationRxPause,
  output logic txPauseEnable,
  output logic rxPauseEnable,
  // aging
  input wire logic [N_PORTS-1:0] linkUp,
  output logic ageTick,
  output logic ageAllFlush,
  output logic fastAgeActive
);
  typedef struct packed {
    logic [7:0] dropLinkage;
    logic [7:0] filterAging;
    logic strapDone;
    logic [7:0] rdData;
    logic rdValid;
    logic txPauseEn;
    logic rxPauseEn;
    logic verdictValid;
    logic verdictDrop;
    logic [3:0] verdictReason;
  } bank_state_t;

  bank_state_t s;
  bank_state_t next_s;

  switch_cfg_if cfg ();

  // address match, shared by the read and the write paths
  function automatic logic hitReg(input logic [7:0] addr, input logic [7:0] target);
    hitReg = (addr == target);
  endfunction : hitReg

  // readback of a register; unmapped offsets read zero
  function automatic logic [7:0] readReg(input logic [7:0] addr, input bank_state_t st);
    if (hitReg(addr, switch_cfg_pkg::ADDR_DROP_LINKAGE))
      readReg = st.dropLinkage & switch_cfg_pkg::MASK_DROP_LINKAGE;
    else if (hitReg(addr, switch_cfg_pkg::ADDR_FILTER_AGING))
      readReg = st.filterAging;
    else
      readReg = 8'h00;
  endfunction : readReg

  // control bits seen by the filter this cycle
  logic passAll;
  logic longFrame;
  logic lenCheck;
  logic confDrop;
  logic [11:0] maxBytes;
  logic pauseHit;
  logic oversize;
  logic lenMismatch;

  assign passAll = s.filterAging[switch_cfg_pkg::BIT_PASS_ALL];
  assign longFrame = s.filterAging[switch_cfg_pkg::BIT_LONG_FRAME];
  assign lenCheck = s.filterAging[switch_cfg_pkg::BIT_LEN_CHECK];
  assign confDrop = s.dropLinkage[switch_cfg_pkg::BIT_CONF_DROP];

  // size limit follows the long-frame bit frame by frame
  assign maxBytes = longFrame ? switch_cfg_pkg::LONG_FRAME_BYTES : STD_FRAME_BYTES;

  // pause class depends on the conformance drop mode
  always_comb
  begin
    if (confDrop)
      pauseHit = (frameTypeLen == switch_cfg_pkg::PAUSE_ETHERTYPE)
        || (frameDestAddr == switch_cfg_pkg::RESERVED_MC_DA);
    else
      pauseHit = frameIsPause;
  end

  assign oversize = frameBytes > maxBytes;

  // only length values under the limit are checked, larger ones are types
  assign lenMismatch = lenCheck && (frameTypeLen < switch_cfg_pkg::LEN_CHECK_LIMIT)
    && (frameTypeLen != {4'h0, framePayloadBytes});

  // register bank, strap capture, pause gating and frame verdict
  always_comb
  begin
    next_s = s;
    next_s.rdValid = 1'b0;
    next_s.verdictValid = 1'b0;

    // strap caught once, on the first edge after reset release
    if (!s.strapDone)
    begin
      next_s.strapDone = 1'b1;
      next_s.filterAging[switch_cfg_pkg::BIT_TX_PAUSE_DIS] = pauseDisableStrapPin;
      next_s.filterAging[switch_cfg_pkg::BIT_RX_PAUSE_DIS] = pauseDisableStrapPin;
    end

    // software write; it wins over the strap load in the same cycle
    if (regWrite)
    begin
      if (hitReg(regAddr, switch_cfg_pkg::ADDR_DROP_LINKAGE))
        next_s.dropLinkage = regWrData & switch_cfg_pkg::MASK_DROP_LINKAGE;
      if (hitReg(regAddr, switch_cfg_pkg::ADDR_FILTER_AGING))
        next_s.filterAging = regWrData;
    end

    // read returns the value held before any same-cycle write
    if (regRead)
    begin
      next_s.rdData = readReg(regAddr, s);
      next_s.rdValid = 1'b1;
    end

    // pause enables track autonegotiation unless forced off
    next_s.txPauseEn = autonegotiationTxPause && !next_s.filterAging[switch_cfg_pkg::BIT_TX_PAUSE_DIS];
    next_s.rxPauseEn = autonegotiationRxPause && !next_s.filterAging[switch_cfg_pkg::BIT_RX_PAUSE_DIS];

    // one verdict per descriptor, using the bits as they stand now
    if (frameValid)
    begin
      next_s.verdictValid = 1'b1;
      next_s.verdictDrop = 1'b0;
      next_s.verdictReason = switch_cfg_pkg::REASON_NONE;
      if (passAll)
      begin
        // debug pass-through overrides every drop cause
        next_s.verdictDrop = 1'b0;
      end
      else if (pauseHit)
      begin
        next_s.verdictDrop = 1'b1;
        next_s.verdictReason = switch_cfg_pkg::REASON_PAUSE;
      end
      else if (frameErrored)
      begin
        next_s.verdictDrop = 1'b1;
        next_s.verdictReason = switch_cfg_pkg::REASON_ERRORED;
      end
      else if (oversize)
      begin
        next_s.verdictDrop = 1'b1;
        next_s.verdictReason = switch_cfg_pkg::REASON_OVERSIZE;
      end
      else if (lenMismatch)
      begin
        next_s.verdictDrop = 1'b1;
        next_s.verdictReason = switch_cfg_pkg::REASON_LENGTH;
      end
    end
  end

  // aging enable comes out of reset set, pause bits cleared until strap
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.dropLinkage <= switch_cfg_pkg::RST_DROP_LINKAGE;
      s.filterAging <= switch_cfg_pkg::RST_FILTER_AGING;
    end
    else
      s <= next_s;
  end

  // aging controls handed to the timer and the link monitor
  assign cfg.ageEnable = s.filterAging[switch_cfg_pkg::BIT_AGE_EN];
  assign cfg.fastAge = s.filterAging[switch_cfg_pkg::BIT_FAST_AGE];
  assign cfg.linkChangeAge = s.dropLinkage[switch_cfg_pkg::BIT_LINK_AGE];

  age_timer #(
    .NORMAL_AGE_CYCLES(NORMAL_AGE_CYCLES),
    .FAST_AGE_CYCLES(FAST_AGE_CYCLES)
  ) u_age_timer (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfg)
  );

  link_loss_monitor #(
    .N_PORTS(N_PORTS)
  ) u_link_loss_monitor (
    .clk(clk),
    .rstn(rstn),
    .linkUp(linkUp),
    .cfg(cfg)
  );

  // outputs straight from flip-flops here or in the children
  assign regRdData = s.rdData;
  assign regRdValid = s.rdValid;
  assign verdictValid = s.verdictValid;
  assign verdictDrop = s.verdictDrop;
  assign verdictReason = s.verdictReason;
  assign txPauseEnable = s.txPauseEn;
  assign rxPauseEnable = s.rxPauseEn;
  assign ageTick = cfg.ageTick;
  assign ageAllFlush = cfg.ageAllFlush;
  assign fastAgeActive = cfg.fastActive;
endmodule : switch_global_frame_aging_control

// [sim/switch_global_frame_aging_control_asserts.sv]
`timescale 1ns/1ps
module switch_global_frame_aging_control_asserts #(
  parameter int N_PORTS = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic regRead,
  input wire logic regRdValid,
  input wire logic frameValid,
  input wire logic [15:0] frameTypeLen,
  input wire logic [47:0] frameDestAddr,
  input wire logic frameIsPause,
  input wire logic frameErrored,
  input wire logic [11:0] frameBytes,
  input wire logic verdictValid,
  input wire logic verdictDrop,
  input wire logic [3:0] verdictReason,
  input wire logic autonegotiationTxPause,
  input wire logic autonegotiationRxPause,
  input wire logic txPauseEnable,
  input wire logic rxPauseEnable,
  input wire logic [N_PORTS-1:0] linkUp,
  input wire logic ageTick,
  input wire logic ageAllFlush
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  // ticks stay apart by at least the shortest period
  sequence quiet_s;
    !ageTick [*5];
  endsequence
  // a frame that no filter can claim
  sequence clean_s;
    frameValid && !frameErrored && !frameIsPause && frameBytes <= 12'h5EE && frameTypeLen >= 16'h05DC
      && frameTypeLen != 16'h8808 && frameDestAddr != 48'h0180C2000001;
  endsequence
  rd_answer_a: assert property (regRead |=> regRdValid) else $error("read unanswered");
  verdict_pulse_a: assert property (frameValid |=> verdictValid) else $error("no verdict");
  drop_reason_a: assert property (verdictValid |-> verdictDrop == (verdictReason != 4'h0)) else $error("reason");
  clean_forward_a: assert property (clean_s |=> !verdictDrop) else $error("clean frame dropped");
  tx_off_a: assert property (!autonegotiationTxPause |=> !txPauseEnable) else $error("tx pause on");
  rx_off_a: assert property (!autonegotiationRxPause |=> !rxPauseEnable) else $error("rx pause on");
  flush_cause_a: assert property (ageAllFlush |-> |($past(linkUp, 2) & ~$past(linkUp))) else $error("flush");
  tick_space_a: assert property (ageTick |=> quiet_s) else $error("ticks too close");
endmodule : switch_global_frame_aging_control_asserts

bind switch_global_frame_aging_control switch_global_frame_aging_control_asserts #(.N_PORTS(N_PORTS)) chk (.*);

// [sim/switch_global_frame_aging_control_test.sv]
`timescale 1ns/1ps
module switch_global_frame_aging_control_test;
  localparam int FAST = 6;
  localparam int NORM = 40;
  localparam logic [47:0] OTH = 48'h0A0000000001;
  localparam logic [47:0] RMC = 48'h0180C2000001;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic strap = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic [7:0] rdData;
  logic rdValid;
  logic fv = 1'b0;
  logic [15:0] tl = 16'h0000;
  logic [47:0] da = 48'h000000000000;
  logic isPause = 1'b0;
  logic errored = 1'b0;
  logic [11:0] bytes = 12'h000;
  logic [11:0] pay = 12'h000;
  logic vValid;
  logic vDrop;
  logic [3:0] vReason;
  logic anTx = 1'b1;
  logic anRx = 1'b1;
  logic txEn;
  logic rxEn;
  logic [3:0] linkUp = 4'hF;
  logic ageTick;
  logic flush;
  logic fastAct;
  int numErrors = 0;
  int numChecks = 0;
  int n;

  // short periods keep the aging runs brief
  switch_global_frame_aging_control #(.N_PORTS(4), .NORMAL_AGE_CYCLES(32'h28), .FAST_AGE_CYCLES(32'h6)) uut (
    .clk(clk), .rstn(rstn), .pauseDisableStrapPin(strap), .regAddr(addr), .regWrite(wrEn), .regRead(rdEn),
    .regWrData(wrData), .regRdData(rdData), .regRdValid(rdValid), .frameValid(fv), .frameTypeLen(tl),
    .frameDestAddr(da), .frameIsPause(isPause), .frameErrored(errored), .frameBytes(bytes),
    .framePayloadBytes(pay), .verdictValid(vValid), .verdictDrop(vDrop), .verdictReason(vReason),
    .autonegotiationTxPause(anTx), .autonegotiationRxPause(anRx), .txPauseEnable(txEn),
    .rxPauseEnable(rxEn), .linkUp(linkUp), .ageTick(ageTick), .ageAllFlush(flush), .fastAgeActive(fastAct)
  );

  always #50 clk = ~clk;

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task closeOut;
    if (numErrors == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : closeOut

  // inputs move at the falling edge; an idle cycle after each request keeps strobes from being redriven
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    @(negedge clk);
    wrEn = 1'b0;
    @(negedge clk);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rdEn = 1'b1;
    @(negedge clk);
    rdEn = 1'b0;
    chk("regRdValid", 1, rdValid);
    chk("regRdData", exp, rdData);
    @(negedge clk);
  endtask : rd

  task fr(input logic [15:0] t, input logic [47:0] d, input logic p, input logic e, input logic [11:0] b,
    input logic [11:0] l, input logic drop, input logic [3:0] why);
    tl = t;
    da = d;
    isPause = p;
    errored = e;
    bytes = b;
    pay = l;
    fv = 1'b1;
    @(negedge clk);
    fv = 1'b0;
    chk("verdictValid", 1, vValid);
    chk("verdictDrop", drop, vDrop);
    chk("verdictReason", why, vReason);
    @(negedge clk);
  endtask : fr

  // cycles from one tick to the next, bounded against a stuck timer
  task gap(input int exp);
    n = 0;
    while (ageTick !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (ageTick !== 1'b1 && n < 200);
    chk("tickGap", exp, n);
  endtask : gap

  initial
  begin
    #(3000 * 100);
    numErrors++;
    closeOut();
  end

  initial
  begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    rd(8'h03, 8'h34);
    chk("txPauseEnable", 0, txEn);
    wr(8'h03, 8'h24);
    chk("rxPauseEnable", 1, rxEn);
    chk("txPauseEnable", 0, txEn);
    wr(8'h03, 8'h14);
    chk("txPauseEnable", 1, txEn);
    chk("rxPauseEnable", 0, rxEn);
    anTx = 1'b0;
    wr(8'h03, 8'h04);
    chk("txPauseEnable", 0, txEn);
    anTx = 1'b1;
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h03);
    wr(8'h02, 8'h00);
    // pause class follows the drop mode bit
    fr(16'h8808, OTH, 1, 0, 12'h040, 12'h000, 1, 4'h1);
    fr(16'h8808, OTH, 0, 0, 12'h040, 12'h000, 0, 4'h0);
    fr(16'h0800, RMC, 0, 0, 12'h040, 12'h000, 0, 4'h0);
    wr(8'h02, 8'h02);
    fr(16'h8808, OTH, 0, 0, 12'h040, 12'h000, 1, 4'h1);
    fr(16'h0800, RMC, 0, 0, 12'h040, 12'h000, 1, 4'h1);
    fr(16'h0800, OTH, 1, 0, 12'h040, 12'h000, 0, 4'h0);
    fr(16'h0800, OTH, 0, 1, 12'h040, 12'h000, 1, 4'h2);
    wr(8'h03, 8'h84);
    fr(16'h0800, OTH, 0, 1, 12'h040, 12'h000, 0, 4'h0);
    fr(16'h8808, OTH, 0, 0, 12'h040, 12'h000, 0, 4'h0);
    wr(8'h03, 8'h04);
    fr(16'h0800, OTH, 0, 0, 12'h7D0, 12'h000, 1, 4'h3);
    wr(8'h03, 8'h44);
    fr(16'h0800, OTH, 0, 0, 12'h800, 12'h000, 0, 4'h0);
    fr(16'h0800, OTH, 0, 0, 12'h801, 12'h000, 1, 4'h3);
    wr(8'h03, 8'h0C);
    fr(16'h0040, OTH, 0, 0, 12'h040, 12'h030, 1, 4'h4);
    fr(16'h0040, OTH, 0, 0, 12'h040, 12'h040, 0, 4'h0);
    fr(16'h05DC, OTH, 0, 0, 12'h040, 12'h000, 0, 4'h0);
    fr(16'h05DB, OTH, 0, 0, 12'h040, 12'h000, 1, 4'h4);
    wr(8'h03, 8'h04);
    fr(16'h0040, OTH, 0, 0, 12'h040, 12'h030, 0, 4'h0);
    gap(NORM);
    // aging off: neither ticks nor flushes, even on a link fall
    wr(8'h03, 8'h00);
    linkUp = 4'hD;
    n = 0;
    repeat (100)
    begin
      @(negedge clk);
      n += int'(ageTick | flush);
    end
    chk("agingOff", 0, n);
    linkUp = 4'hF;
    wr(8'h03, 8'h06);
    gap(FAST);
    chk("fastAgeActive", 1, fastAct);
    wr(8'h03, 8'h04);
    chk("fastAgeActive", 0, fastAct);
    gap(NORM);
    wr(8'h02, 8'h01);
    linkUp = 4'hB;
    n = 0;
    repeat (3)
    begin
      @(negedge clk);
      n += int'(flush);
    end
    chk("ageAllFlush", 1, n);
    chk("fastAgeActive", 1, fastAct);
    n = 0;
    while (ageTick !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk("fastCycle", 1, n <= FAST);
    gap(NORM);
    // second reset with the strap low: both pause bits load clear
    strap = 1'b0;
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    rd(8'h03, 8'h04);
    chk("txPauseEnable", 1, txEn);
    chk("rxPauseEnable", 1, rxEn);
    closeOut();
  end
endmodule : switch_global_frame_aging_control_test
